// ### jtag_tap.sv
// Boundary-scan test access port: TAP controller, instruction and data registers
//
// What this block does
// R1: TMS sampled only on test clock rise
// R2: Power-up: reset state, IDCODE current instruction
// R3: Five TMS-high rises reach Test-Logic-Reset
// R4: Run-Test-Idle holds on low, high selects DR
// R5: Select-DR: low captures, high selects IR
// R6: Capture-DR loads the selected data register
// R7: Shift-DR shifts selected register toward TDO
// R8: Exit1/Pause/Exit2-DR transitions as specified
// R9: Update-DR latches parallel outputs on falling edge
// R10: Select-IR: low captures, high resets
// R11: Capture-IR loads fixed instruction value
// R12: Shift-IR shifts instruction stages toward TDO
// R13: Exit1/Pause/Exit2-IR transitions as specified
// R14: Update-IR latches instruction on falling edge
// R15: Three-bit instruction shift plus parallel latch
// R16: Decode selects boundary, bypass or identification
// R17: EXTEST drives outputs from boundary latches
// R18: HIGHZ floats outputs, bypass in path
// R19: CLAMP holds outputs from latches, bypass path
// R20: SAMPLE snapshots pins, preload via shifting
// R21: IDCODE captures 32-bit code, LSB one
// R22: BYPASS uses one-stage bypass register
// R23: Unlisted codes act as BYPASS
// R24: Test reset pin forces reset state, IDCODE
`timescale 1ns/10ps
`include "jtag_tap_defs.svh"
module jtag_tap
   import jtag_tap_pkg::*;
#(
   parameter int                     N_IN    = 4,
   parameter int                     N_OUT   = 4,
   parameter logic [`ID_VER_W-1:0]   ID_VER  = 4'h0,   // Arbitrary value
   parameter logic [`ID_PART_W-1:0]  ID_PART = 16'h0001, // Arbitrary value
   parameter logic [`ID_MANUF_W-1:0] ID_MANUF = 11'h055 // Arbitrary value
) (
   // Clock, reset, enable
   input  wire logic             i_mclk,
   input  wire logic             i_arst_n,
   input  wire logic             i_ce,
   // Test port pins
   input  wire logic             i_test_reset_n,
   input  wire logic             i_jtag_test_clock,
   input  wire logic             i_tms,
   input  wire logic             i_tdi,
   output logic                  o_tdo,
   output logic                  o_tdo_oe_n,
   // Core side
   input  wire logic [N_OUT-1:0] i_core_out,
   input  wire logic             i_core_oe_n,
   output logic [N_IN-1:0]       o_core_in,
   // Device pins
   input  wire logic [N_IN-1:0]  i_pin_in,
   output logic [N_OUT-1:0]      o_pin_out,
   output logic [N_OUT-1:0]      o_pin_oe_n
);
   localparam int BSR_W = N_IN + N_OUT + 1;
   localparam int CTL   = N_IN + N_OUT;
   localparam logic [`ID_W-1:0] ID_CODE = {ID_VER, ID_PART, ID_MANUF, `ID_LSB_VAL};

   // ------------------------------------------------------------
   // Reset combine and synchronous release
   // ------------------------------------------------------------
   logic rst_comb_n, rst_s1_r, rst_n;
   assign rst_comb_n = i_arst_n & i_test_reset_n; // [R24]

   always_ff @(posedge i_mclk or negedge rst_comb_n) begin
      if (!rst_comb_n) begin
         rst_s1_r <= 1'h0;
         rst_n    <= 1'h0;
      end else begin
         rst_s1_r <= 1'h1;
         rst_n    <= rst_s1_r;
      end
   end

   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   logic [N_IN+2:0] sy1_r, sy1_nxt, sy2_r, sy2_nxt;
   logic            tck_d_r, tck_d_nxt;
   logic            tck_s, tms_s, tdi_s;
   logic [N_IN-1:0] pin_s;

   always_comb begin
      sy1_nxt   = {i_jtag_test_clock, i_tms, i_tdi, i_pin_in};
      sy2_nxt   = sy1_r;
      tck_d_nxt = sy2_r[N_IN+2];
   end

   always_ff @(posedge i_mclk or negedge rst_n) begin
      if (!rst_n) begin
         sy1_r   <= '0;
         sy2_r   <= '0;
         tck_d_r <= 1'h0;
      end else if (i_ce) begin
         sy1_r   <= sy1_nxt;
         sy2_r   <= sy2_nxt;
         tck_d_r <= tck_d_nxt;
      end
   end

   assign tck_s = sy2_r[N_IN+2];
   assign tms_s = sy2_r[N_IN+1];
   assign tdi_s = sy2_r[N_IN];
   assign pin_s = sy2_r[N_IN-1:0];

   // ------------------------------------------------------------
   // Test clock edges and stall by the output buffer
   // ------------------------------------------------------------
   logic rise_evt, fall_evt, pend_r, pend_nxt, go;
   logic buf_in_ready, buf_out_valid;
   logic [`TDO_BUF_W-1:0] buf_in_data, buf_out_data;

   assign rise_evt = tck_s & ~tck_d_r;
   assign fall_evt = ~tck_s & tck_d_r;
   assign go       = (pend_r | rise_evt) & buf_in_ready; // [R1]

   // Hold a rise until the buffer can take its bit
   always_comb begin
      pend_nxt = (pend_r | rise_evt) & ~go;
   end

   always_ff @(posedge i_mclk or negedge rst_n) begin
      if (!rst_n) begin
         pend_r <= 1'h0;
      end else if (i_ce) begin
         pend_r <= pend_nxt;
      end
   end

   // ------------------------------------------------------------
   // TAP controller
   // ------------------------------------------------------------
   tap_state_type state_r, state_nxt;

   // Next state from TMS on each accepted rise
   always_comb begin
      state_nxt = state_r;
      if (go) begin
         case (state_r)
            ST_TLR:   state_nxt = tms_s ? ST_TLR   : ST_RTI;   // [R3]
            ST_RTI:   state_nxt = tms_s ? ST_SELDR : ST_RTI;   // [R4]
            ST_SELDR: state_nxt = tms_s ? ST_SELIR : ST_CAPDR; // [R5]
            ST_CAPDR: state_nxt = tms_s ? ST_EX1DR : ST_SHDR;  // [R6]
            ST_SHDR:  state_nxt = tms_s ? ST_EX1DR : ST_SHDR;  // [R7]
            ST_EX1DR: state_nxt = tms_s ? ST_UPDR  : ST_PSDR;  // [R8]
            ST_PSDR:  state_nxt = tms_s ? ST_EX2DR : ST_PSDR;  // [R8]
            ST_EX2DR: state_nxt = tms_s ? ST_UPDR  : ST_SHDR;  // [R8]
            ST_UPDR:  state_nxt = tms_s ? ST_SELDR : ST_RTI;
            ST_SELIR: state_nxt = tms_s ? ST_TLR   : ST_CAPIR; // [R10]
            ST_CAPIR: state_nxt = tms_s ? ST_EX1IR : ST_SHIR;  // [R11]
            ST_SHIR:  state_nxt = tms_s ? ST_EX1IR : ST_SHIR;  // [R12]
            ST_EX1IR: state_nxt = tms_s ? ST_UPIR  : ST_PSIR;  // [R13]
            ST_PSIR:  state_nxt = tms_s ? ST_EX2IR : ST_PSIR;  // [R13]
            ST_EX2IR: state_nxt = tms_s ? ST_UPIR  : ST_SHIR;  // [R13]
            ST_UPIR:  state_nxt = tms_s ? ST_SELDR : ST_RTI;   // [R14]
            default:  state_nxt = ST_TLR;
         endcase
      end
   end

   always_ff @(posedge i_mclk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= ST_TLR; // [R2]
      end else if (i_ce) begin
         state_r <= state_nxt;
      end
   end

   // ------------------------------------------------------------
   // Instruction and data registers
   // ------------------------------------------------------------
   logic [`IR_W-1:0] irs_r, irs_nxt, ir_r, ir_nxt;
   logic [BSR_W-1:0] bsh_r, bsh_nxt, bup_r, bup_nxt;
   logic [`ID_W-1:0] id_r, id_nxt;
   logic             byp_r, byp_nxt;
   logic             sel_bsr, sel_id, ir_ext, ir_clamp, ir_highz;

   // Decode; unlisted codes fall to bypass
   assign sel_bsr  = (ir_r == `IR_EXTEST) || (ir_r == `IR_SAMPLE); // [R16]
   assign sel_id   = (ir_r == `IR_IDCODE);                          // [R16]
   assign ir_ext   = (ir_r == `IR_EXTEST);
   assign ir_clamp = (ir_r == `IR_CLAMP);
   assign ir_highz = (ir_r == `IR_HIGHZ);

   // Capture and shift on rises, latches on falls
   always_comb begin
      irs_nxt = irs_r;
      ir_nxt  = ir_r;
      bsh_nxt = bsh_r;
      bup_nxt = bup_r;
      id_nxt  = id_r;
      byp_nxt = byp_r;
      if (go) begin
         case (state_r)
            ST_CAPDR: begin
               if (sel_bsr) begin
                  bsh_nxt = {i_core_oe_n, i_core_out, pin_s}; // [R6] [R17] [R20]
               end else if (sel_id) begin
                  id_nxt = ID_CODE; // [R21]
               end else begin
                  byp_nxt = `BYPASS_CAPTURE; // [R22] [R23]
               end
            end
            ST_SHDR: begin
               if (sel_bsr) begin
                  bsh_nxt = {tdi_s, bsh_r[BSR_W-1:1]}; // [R7] [R20]
               end else if (sel_id) begin
                  id_nxt = {tdi_s, id_r[`ID_W-1:1]}; // [R7] [R21]
               end else begin
                  byp_nxt = tdi_s; // [R22] [R18] [R19]
               end
            end
            ST_CAPIR: irs_nxt = `IR_CAPTURE_VAL;             // [R11]
            ST_SHIR:  irs_nxt = {tdi_s, irs_r[`IR_W-1:1]};  // [R12] [R15]
            default:  irs_nxt = irs_r;
         endcase
      end
      if (state_r == ST_TLR) begin
         ir_nxt = `IR_IDCODE; // [R2]
      end else if (fall_evt && state_r == ST_UPIR) begin
         ir_nxt = irs_r; // [R14] [R15]
      end
      if (fall_evt && state_r == ST_UPDR && sel_bsr) begin
         bup_nxt = bsh_r; // [R9]
      end
   end

   always_ff @(posedge i_mclk or negedge rst_n) begin
      if (!rst_n) begin
         irs_r <= `IR_CAPTURE_VAL;
         ir_r  <= `IR_IDCODE; // [R2] [R24]
         bsh_r <= '0;
         bup_r <= '0;
         id_r  <= '0;
         byp_r <= 1'h0;
      end else if (i_ce) begin
         irs_r <= irs_nxt;
         ir_r  <= ir_nxt;
         bsh_r <= bsh_nxt;
         bup_r <= bup_nxt;
         id_r  <= id_nxt;
         byp_r <= byp_nxt;
      end
   end

   // ------------------------------------------------------------
   // Serial output path through the buffer
   // ------------------------------------------------------------
   logic tdo_bit, shifting;

   // Bit presented after this rise, with its drive state
   always_comb begin
      shifting = (state_nxt == ST_SHDR) || (state_nxt == ST_SHIR);
      if (state_nxt == ST_SHIR) begin
         tdo_bit = irs_nxt[0];
      end else if (sel_bsr) begin
         tdo_bit = bsh_nxt[0];
      end else if (sel_id) begin
         tdo_bit = id_nxt[0];
      end else begin
         tdo_bit = byp_nxt;
      end
      buf_in_data = {shifting, tdo_bit};
   end

   tdo_buffer #(
      .WIDTH (`TDO_BUF_W),
      .DEPTH (2)
   ) u_tdo_buf (
      .i_mclk      (i_mclk),
      .i_arst_n    (rst_n),
      .i_ce        (i_ce),
      .i_in_valid  (pend_r | rise_evt),
      .o_in_ready  (buf_in_ready),
      .i_in_data   (buf_in_data),
      .o_out_valid (buf_out_valid),
      .i_out_ready (fall_evt),
      .o_out_data  (buf_out_data)
   );

   // ------------------------------------------------------------
   // Output registers: TDO and device pins
   // ------------------------------------------------------------
   logic             tdo_nxt, tdo_oe_n_nxt;
   logic [N_OUT-1:0] pin_out_nxt, pin_oe_n_nxt;

   // TDO changes on the falling edge; pins follow the mode
   always_comb begin
      tdo_nxt      = o_tdo;
      tdo_oe_n_nxt = o_tdo_oe_n;
      if (fall_evt && buf_out_valid) begin
         tdo_nxt      = buf_out_data[0];
         tdo_oe_n_nxt = ~buf_out_data[1];
      end
      if (ir_highz) begin
         pin_out_nxt  = i_core_out;
         pin_oe_n_nxt = '1; // [R18]
      end else if (ir_ext || ir_clamp) begin
         pin_out_nxt  = bup_r[CTL-1:N_IN];     // [R17] [R19]
         pin_oe_n_nxt = {N_OUT{bup_r[CTL]}};   // [R17] [R19]
      end else begin
         pin_out_nxt  = i_core_out;             // [R20] [R22] [R23]
         pin_oe_n_nxt = {N_OUT{i_core_oe_n}};
      end
   end

   always_ff @(posedge i_mclk or negedge rst_n) begin
      if (!rst_n) begin
         o_tdo      <= 1'h0;
         o_tdo_oe_n <= 1'h1;
         o_pin_out  <= '0;
         o_pin_oe_n <= '1;
         o_core_in  <= '0;
      end else if (i_ce) begin
         o_tdo      <= tdo_nxt;
         o_tdo_oe_n <= tdo_oe_n_nxt;
         o_pin_out  <= pin_out_nxt;
         o_pin_oe_n <= pin_oe_n_nxt;
         o_core_in  <= pin_s;
      end
   end

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!rst_n);

   logic [2:0] ones_cnt_r;
   always_ff @(posedge i_mclk or negedge rst_n) begin
      if (!rst_n) begin
         ones_cnt_r <= 3'h0;
      end else if (go && i_ce) begin
         ones_cnt_r <= !tms_s ? 3'h0 : (ones_cnt_r == `TLR_TMS_ONES) ? ones_cnt_r : ones_cnt_r + 3'h1;
      end
   end

   sequence s_upir_fall;
      (state_r == ST_UPIR) && fall_evt && i_ce;
   endsequence
   sequence s_id_capture;
      (state_r == ST_CAPDR) && go && i_ce && sel_id;
   endsequence

   a_five_ones_reset: assert property (ones_cnt_r == `TLR_TMS_ONES |-> state_r == ST_TLR) // [R3]
      else $error("five TMS-high rises did not reach reset");
   a_idle_hold: assert property ((state_r == ST_RTI) && go && i_ce && !tms_s |=> state_r == ST_RTI) // [R4]
      else $error("idle state left with TMS low");
   a_seldr_capture: assert property ((state_r == ST_SELDR) && go && i_ce |=> // [R5]
      state_r == ($past(tms_s) ? ST_SELIR : ST_CAPDR))
      else $error("wrong exit from select-DR");
   a_selir_reset: assert property ((state_r == ST_SELIR) && go && i_ce && tms_s |=> state_r == ST_TLR) // [R10]
      else $error("select-IR with TMS high did not reset");
   a_ir_capture: assert property ((state_r == ST_CAPIR) && go && i_ce |=> irs_r == `IR_CAPTURE_VAL) // [R11]
      else $error("instruction capture value wrong");
   a_ir_update: assert property (s_upir_fall |=> ir_r == $past(irs_r)) // [R14]
      else $error("instruction not latched on falling edge");
   a_reset_idcode: assert property (state_r == ST_TLR && i_ce |=> ir_r == `IR_IDCODE) // [R2]
      else $error("reset state without IDCODE");
   a_id_capture: assert property (s_id_capture |=> id_r == ID_CODE && id_r[0] == `ID_LSB_VAL) // [R21]
      else $error("identification code not captured");
   a_highz_pins: assert property (ir_highz && i_ce |=> o_pin_oe_n == '1) // [R18]
      else $error("outputs not floated under HIGHZ");
   a_ir_hold_shift: assert property ((state_r == ST_SHIR) && !fall_evt |=> ir_r == $past(ir_r)) // [R12]
      else $error("current instruction changed while shifting");

endmodule : jtag_tap

// ### jtag_tap_boundary_scan_tb_top.sv
// Self-checking testbench of the boundary-scan test access port
`timescale 1ns/10ps
`include "jtag_tap_defs.svh"
module jtag_tap_boundary_scan_tb_top
   import jtag_tap_pkg::*;
;
   // ID fields, arbitrary values
   localparam logic [31:0] ID_EXP = {4'h3, 16'h00a5, 11'h02b, 1'h1};

   logic       i_mclk;
   logic       i_arst_n;
   logic       i_ce;
   logic [3:0] core_out;
   logic       core_oe_n;
   logic [3:0] pin_in;
   wire        jtck;
   wire        tms;
   wire        tdi;
   wire        trst_n;
   wire        tdo;
   wire        tdo_oe_n;
   wire  [3:0] core_in;
   wire  [3:0] pin_out;
   wire  [3:0] pin_oe_n;
   int         errors;
   int         n_tests;
   int         cycles;
   logic       s;

   jtag_tap #(.ID_VER(4'h3), .ID_PART(16'h00a5), .ID_MANUF(11'h02b)) DUT (
      .i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_ce(i_ce), .i_test_reset_n(trst_n),
      .i_jtag_test_clock(jtck), .i_tms(tms), .i_tdi(tdi), .o_tdo(tdo), .o_tdo_oe_n(tdo_oe_n),
      .i_core_out(core_out), .i_core_oe_n(core_oe_n), .o_core_in(core_in),
      .i_pin_in(pin_in), .o_pin_out(pin_out), .o_pin_oe_n(pin_oe_n));

   jtag_tester tst (
      .o_jtag_test_clock(jtck), .o_tms(tms), .o_tdi(tdi), .o_test_reset_n(trst_n),
      .i_tdo(tdo), .i_tdo_oe_n(tdo_oe_n));

   // ------------------------------------------------------------
   // Checking and closing
   // ------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic final_report;
      $display("Comparisons %0d, mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : final_report

   // Pins follow the core in normal modes; TDO released outside shifts
   task automatic check_core;
      repeat (4) @(negedge i_mclk);
      check({23'h0, tdo_oe_n, pin_oe_n, pin_out}, {23'h0, 1'h1, {4{core_oe_n}}, core_out});
   endtask : check_core

   task automatic check_id;
      logic [31:0] d;
      tst.scan(1'b0, 32, 32'h0, 1'b0, d);
      check(d, ID_EXP);
   endtask : check_id

   // Instruction load; capture value comes out first
   task automatic load_ir(input logic [2:0] c, input bit pause);
      logic [31:0] d;
      tst.scan(1'b1, 3, {29'h0, c}, pause, d);
      check(d, {29'h0, `IR_CAPTURE_VAL});
   endtask : load_ir

   task automatic bypass_scan;
      logic [31:0] d;
      tst.scan(1'b0, 8, 32'hb6, 1'b0, d);
      check(d, 32'h6c);
   endtask : bypass_scan

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_bypass_codes;
      logic [2:0] codes [3];
      codes = '{`IR_BYPASS, 3'h1, 3'h5};
      foreach (codes[k]) begin
         load_ir(codes[k], 1'b0);
         bypass_scan();
         check_core();
      end
   endtask : t_bypass_codes

   task automatic t_sample;
      logic [31:0] d;
      @(negedge i_mclk);
      pin_in = 4'ha;
      core_out = 4'h5;
      load_ir(`IR_SAMPLE, 1'b1);
      tst.scan(1'b0, 9, 32'h0c3, 1'b1, d);
      check(d, 32'h05a);
      check_core();
      check({28'h0, core_in}, 32'ha);
   endtask : t_sample

   task automatic t_extest;
      logic [31:0] d;
      load_ir(`IR_EXTEST, 1'b0);
      repeat (4) @(negedge i_mclk);
      check({24'h0, pin_oe_n, pin_out}, 32'h0c);
      pin_in = 4'h6;
      tst.scan(1'b0, 9, 32'h0a9, 1'b0, d);
      check(d, 32'h056);
      repeat (4) @(negedge i_mclk);
      check({24'h0, pin_oe_n, pin_out}, 32'h0a);
   endtask : t_extest

   task automatic t_clamp;
      load_ir(`IR_CLAMP, 1'b0);
      @(negedge i_mclk);
      core_out = 4'h3;
      bypass_scan();
      check({24'h0, pin_oe_n, pin_out}, 32'h0a);
   endtask : t_clamp

   task automatic t_highz;
      load_ir(`IR_HIGHZ, 1'b0);
      repeat (4) @(negedge i_mclk);
      check({28'h0, pin_oe_n}, 32'hf);
      bypass_scan();
   endtask : t_highz

   // Three ways back to reset: select-IR exit, five ones, test reset pin
   task automatic t_resets;
      load_ir(`IR_EXTEST, 1'b0);
      tst.tck(1'b1, 1'b0, s);
      tst.tck(1'b1, 1'b0, s);
      tst.tck(1'b1, 1'b0, s);
      tst.tck(1'b0, 1'b0, s);
      check_core();
      check_id();
      load_ir(`IR_EXTEST, 1'b0);
      tst.tck(1'b1, 1'b0, s);
      tst.tck(1'b0, 1'b0, s);
      tst.tck(1'b0, 1'b0, s);
      tst.to_idle();
      check_core();
      load_ir(`IR_EXTEST, 1'b0);
      tst.trst();
      tst.tck(1'b0, 1'b0, s);
      check_core();
      check_id();
   endtask : t_resets

   // Clock enable low freezes the pins, then they follow the core again
   task automatic t_freeze;
      @(negedge i_mclk);
      i_ce = 1'b0;
      core_out = 4'hc;
      repeat (4) @(negedge i_mclk);
      check({24'h0, pin_oe_n, pin_out}, 32'h03);
      i_ce = 1'b1;
      check_core();
   endtask : t_freeze

   // ------------------------------------------------------------
   // Clock, timeout, main sequence
   // ------------------------------------------------------------
   initial begin
      i_mclk = 1'b0;
      forever #2.5 i_mclk = ~i_mclk;
   end

   // Whole run needs about 3100 cycles
   always @(posedge i_mclk) begin
      cycles++;
      if (cycles == 40000) begin
         errors++;
         final_report();
      end
   end

   initial begin
      errors = 0;
      n_tests = 0;
      cycles = 0;
      i_arst_n = 1'b0;
      i_ce = 1'b1;
      core_out = 4'h9;
      core_oe_n = 1'b0;
      pin_in = 4'h0;
      repeat (10) @(negedge i_mclk);
      i_arst_n = 1'b1;
      repeat (6) @(negedge i_mclk);
      check_core();
      tst.tck(1'b0, 1'b0, s);
      check_id();
      t_bypass_codes();
      t_sample();
      t_extest();
      t_clamp();
      t_highz();
      t_resets();
      t_freeze();
      final_report();
   end
endmodule : jtag_tap_boundary_scan_tb_top

// ### jtag_tap_defs.svh
// Constants of the boundary-scan test access port
`ifndef JTAG_TAP_DEFS_SVH
`define JTAG_TAP_DEFS_SVH

// ------------------------------------------------------------
// Instruction register
// ------------------------------------------------------------
`define IR_W            3
`define IR_EXTEST       3'h0
`define IR_HIGHZ        3'h2
`define IR_CLAMP        3'h3
`define IR_SAMPLE       3'h4
`define IR_IDCODE       3'h6
`define IR_BYPASS       3'h7
`define IR_CAPTURE_VAL  3'h1

// ------------------------------------------------------------
// Identification register layout
// ------------------------------------------------------------
`define ID_W            32
`define ID_LSB_VAL      1'h1
`define ID_MANUF_W      11
`define ID_PART_W       16
`define ID_VER_W        4

// ------------------------------------------------------------
// Misc
// ------------------------------------------------------------
`define TLR_TMS_ONES    3'h5
`define BYPASS_CAPTURE  1'h0
`define TDO_BUF_W       2

`endif

// ### jtag_tap_pkg.sv
// Types shared by the test access port design
package jtag_tap_pkg;

   // TAP controller states, one-hot
   typedef enum logic [15:0] {
      ST_TLR   = 16'h0001,
      ST_RTI   = 16'h0002,
      ST_SELDR = 16'h0004,
      ST_CAPDR = 16'h0008,
      ST_SHDR  = 16'h0010,
      ST_EX1DR = 16'h0020,
      ST_PSDR  = 16'h0040,
      ST_EX2DR = 16'h0080,
      ST_UPDR  = 16'h0100,
      ST_SELIR = 16'h0200,
      ST_CAPIR = 16'h0400,
      ST_SHIR  = 16'h0800,
      ST_EX1IR = 16'h1000,
      ST_PSIR  = 16'h2000,
      ST_EX2IR = 16'h4000,
      ST_UPIR  = 16'h8000
   } tap_state_type;

endpackage : jtag_tap_pkg

// ### jtag_tester.sv
// Behavioural boundary-scan tester that drives the test port pins
`timescale 1ns/10ps
module jtag_tester (
   // Test port drive
   output logic      o_jtag_test_clock,
   output logic      o_tms,
   output logic      o_tdi,
   output logic      o_test_reset_n,
   // Test port return
   input  wire logic i_tdo,
   input  wire logic i_tdo_oe_n
);
   // ------------------------------------------------------------
   // Line model
   // ------------------------------------------------------------
   logic last_tdo;
   logic tdo_line;

   // Idle levels; test clock stands low outside frames
   initial begin
      o_jtag_test_clock = 1'b0;
      o_tms             = 1'b1;
      o_tdi             = 1'b0;
      o_test_reset_n    = 1'b1;
      last_tdo          = 1'b0;
   end

   // Released line shows the inverse of the last driven bit
   always @(i_tdo or i_tdo_oe_n) begin
      if (i_tdo_oe_n === 1'b0) begin
         last_tdo = i_tdo;
      end
   end
   assign tdo_line = (i_tdo_oe_n === 1'b0) ? i_tdo : ~last_tdo;

   // ------------------------------------------------------------
   // Link tasks
   // ------------------------------------------------------------
   // One 48 ns test clock cycle; TDO sampled mid high phase
   task automatic tck(input logic tms, input logic tdi, output logic tdo_s);
      o_tms = tms;
      o_tdi = tdi;
      #24;
      o_jtag_test_clock = 1'b1;
      #12;
      tdo_s = tdo_line;
      #12;
      o_jtag_test_clock = 1'b0;
   endtask : tck

   // Five TMS-high rises force reset, then park in idle
   task automatic to_idle;
      logic s;
      #0.7;
      repeat (5) tck(1'b1, 1'b0, s);
      tck(1'b0, 1'b0, s);
   endtask : to_idle

   // Pulse of the test reset pin
   task automatic trst;
      o_test_reset_n = 1'b0;
      #30;
      o_test_reset_n = 1'b1;
      #40;
   endtask : trst

   // Scan from idle back to idle, LSB first, optional pause midway
   task automatic scan(input bit ir, input int len, input logic [31:0] din, input bit pause,
                       output logic [31:0] dout);
      logic s;
      int   i;
      dout = '0;
      tck(1'b1, 1'b0, s);
      if (ir) tck(1'b1, 1'b0, s);
      tck(1'b0, 1'b0, s);
      tck(1'b0, 1'b0, s);
      for (i = 0; i < len; i++) begin
         tck((i == len - 1) || (pause && i == len / 2 - 1), din[i], s);
         dout[i] = s;
         if (pause && i == len / 2 - 1 && i != len - 1) begin
            tck(1'b0, 1'b0, s);
            tck(1'b0, 1'b0, s);
            tck(1'b1, 1'b0, s);
            tck(1'b0, 1'b0, s);
         end
      end
      tck(1'b1, 1'b0, s);
      tck(1'b0, 1'b0, s);
   endtask : scan
endmodule : jtag_tester

// ### tdo_buffer.sv
// Two-entry valid/ready buffer for serial output bits
`timescale 1ns/10ps
module tdo_buffer #(
   parameter int WIDTH = 2,
   parameter int DEPTH = 2
) (
   // Clock and reset
   input  wire logic             i_mclk,
   input  wire logic             i_arst_n,
   input  wire logic             i_ce,
   // Fill side
   input  wire logic             i_in_valid,
   output logic                  o_in_ready,
   input  wire logic [WIDTH-1:0] i_in_data,
   // Drain side
   output logic                  o_out_valid,
   input  wire logic             i_out_ready,
   output logic [WIDTH-1:0]      o_out_data
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);

   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [WIDTH-1:0] mem_nxt [DEPTH];
   logic [AW-1:0]    wptr_r, wptr_nxt, rptr_r, rptr_nxt;
   logic [CW-1:0]    cnt_r, cnt_nxt;
   logic             push, pop;

   // Honest full and empty flags
   assign o_in_ready  = (cnt_r != CW'(DEPTH));
   assign o_out_valid = (cnt_r != '0);
   assign o_out_data  = mem_r[rptr_r];
   assign push        = i_in_valid & o_in_ready;
   assign pop         = i_out_ready & o_out_valid;

   // Next pointers, count and storage
   always_comb begin
      mem_nxt  = mem_r;
      wptr_nxt = wptr_r;
      rptr_nxt = rptr_r;
      cnt_nxt  = cnt_r;
      if (push) begin
         mem_nxt[wptr_r] = i_in_data;
         wptr_nxt = (wptr_r == AW'(DEPTH - 1)) ? '0 : wptr_r + 1'b1;
      end
      if (pop) begin
         rptr_nxt = (rptr_r == AW'(DEPTH - 1)) ? '0 : rptr_r + 1'b1;
      end
      if (push && !pop) begin
         cnt_nxt = cnt_r + 1'b1;
      end else if (pop && !push) begin
         cnt_nxt = cnt_r - 1'b1;
      end
   end

   // Register stage
   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem_r[i] <= '0;
         end
         wptr_r <= '0;
         rptr_r <= '0;
         cnt_r  <= '0;
      end else if (i_ce) begin
         mem_r  <= mem_nxt;
         wptr_r <= wptr_nxt;
         rptr_r <= rptr_nxt;
         cnt_r  <= cnt_nxt;
      end
   end

endmodule : tdo_buffer
